// ### include/psd_pkg.sv
// Constants for the PWM shutdown, sync and fractional adjust block.
// Assumes a 32-bit classic Wishbone master with word-aligned byte addresses.
package psd_pkg;
	// Register byte offsets
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_ASDC = 8'h04;
	localparam logic [7:0] ADR_ASDS = 8'h08;
	localparam logic [7:0] ADR_ASDL = 8'h0C;
	localparam logic [7:0] ADR_SYNC = 8'h10;
	localparam logic [7:0] ADR_PRD  = 8'h14;
	localparam logic [7:0] ADR_PH   = 8'h18;
	localparam logic [7:0] ADR_DC   = 8'h1C;
	localparam logic [7:0] ADR_FFA  = 8'h20;
	localparam logic [7:0] ADR_STAT = 8'h24;
	// Control register fields
	localparam int CTRL_EN   = 7;
	localparam int CTRL_LD   = 6;
	localparam int MODE_LSB  = 0;
	localparam int MODE_W    = 4;
	// Shutdown control register fields
	localparam int ASDC_ASE  = 7;
	localparam int ASDC_EN   = 6;
	localparam int ASDC_OV   = 5;
	localparam int ASDC_ARS  = 4;
	// Sync control register fields
	localparam int SYNC_POF  = 7;
	// Status register fields
	localparam int STAT_HOLD = 5;
	localparam int STAT_WAVE = 4;
	// Fractional adjust width
	localparam int FFA_W     = 4;
	// Operating modes
	localparam logic [3:0] MODE_FIX_SGL = 4'hA;
	localparam logic [3:0] MODE_FIX_CMP = 4'hB;
	// Reset values
	localparam logic [15:0] PRD_RST = 16'hFFFF;
	localparam logic [15:0] ZERO16  = 16'h0000;
	// Restart state
	typedef enum logic [0:0] {
		RS_RUN  = 1'b0,
		RS_HOLD = 1'b1
	} psd_run_t;
endpackage

// ### src/psd_core.sv
// PWM auto-shutdown, period sync and fractional frequency adjust.
// Assumes one 20 MHz clock; sync_in comes from sibling modules on it.
`timescale 1ns/100ps

module psd_core #(
	parameter int N_SRC = 4,
	parameter int N_OUT = 2,
	parameter int N_MOD = 2
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Wishbone slave
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [7:0]       wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	// Shutdown sources from pins
	input  wire logic [N_SRC-1:0] asd_src_i,
	// Sync to and from sibling modules
	input  wire logic [N_MOD-1:0] sync_in,
	output logic                  sync_out,
	// Pins and event
	output logic      [N_OUT-1:0] pwm_out,
	output logic                  asd_event
);
	typedef struct packed {
		logic             ack;
		logic [31:0]      dat;
		logic             en;
		logic             ld;
		logic [3:0]       mode;
		logic             asde;
		logic             asden;
		logic             ovr;
		logic             arsen;
		logic             by_src;
		logic [N_SRC-1:0] sel;
		logic [N_OUT-1:0] lvl;
		logic             pofst;
		logic [N_MOD-1:0] slv;
		logic [15:0]      prd_r;
		logic [15:0]      ph_r;
		logic [15:0]      dc_r;
		logic [15:0]      prd_b;
		logic [15:0]      ph_b;
		logic [15:0]      dc_b;
		logic [3:0]       ffa;
		logic [3:0]       acc;
		logic             ext;
		logic [15:0]      cnt;
		logic             wave;
		psd_pkg::psd_run_t run;
		logic [N_OUT-1:0] pwm;
		logic             sync_o;
		logic             rise_d;
		logic             irq;
		logic [N_SRC-1:0] s1;
		logic [N_SRC-1:0] s2;
		logic [N_SRC-1:0] s3;
		logic [N_SRC-1:0] src;
	} psd_state_t;

	psd_state_t q;
	psd_state_t n;

	logic        acc_wr;
	logic        wr_ctrl;
	logic        wr_asdc;
	logic        hit;
	logic        fixed;
	logic        per_ev;
	logic        rise_ev;
	logic        ovr_on;
	logic [16:0] end_cnt;
	logic [4:0]  acc_sum;
	logic [N_OUT-1:0] wave_v;

	// Write commits at the edge where the master sees ack
	assign acc_wr  = wb_cyc_i & wb_stb_i & wb_we_i & q.ack & wb_sel_i[0];
	assign wr_ctrl = acc_wr & (wb_adr_i == psd_pkg::ADR_CTRL);
	assign wr_asdc = acc_wr & (wb_adr_i == psd_pkg::ADR_ASDC);
	// Stable filtered levels, not edges
	assign hit     = q.asden & |(q.src & q.sel);
	assign fixed   = (q.mode == psd_pkg::MODE_FIX_SGL) | (q.mode == psd_pkg::MODE_FIX_CMP);
	assign end_cnt = {1'b0, q.prd_b} + {16'h0000, q.ext & fixed};
	assign per_ev  = q.en & (({1'b0, q.cnt} >= end_cnt) | |(sync_in & q.slv));
	assign rise_ev = q.en & (q.cnt == q.ph_b);
	assign ovr_on  = q.asde | q.ovr | (q.run == psd_pkg::RS_HOLD);
	assign acc_sum = {1'b0, q.acc} + {1'b0, q.ffa};

	always_comb begin
		n = q;
		n.irq = 1'b0;
		// Three-stage pin filter; s1 feeds only s2
		n.s1 = asd_src_i;
		n.s2 = q.s1;
		n.s3 = q.s2;
		for (int i = 0; i < N_SRC; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				n.src[i] = q.s3[i];
			end
		end
		// Bus answer one cycle after request, dropped next cycle
		n.ack = wb_cyc_i & wb_stb_i & ~q.ack;
		if (wb_cyc_i & wb_stb_i & ~q.ack) begin
			n.dat = 32'h0000_0000;
			case (wb_adr_i)
				psd_pkg::ADR_CTRL: begin
					n.dat[psd_pkg::CTRL_EN] = q.en;
					n.dat[psd_pkg::CTRL_LD] = q.ld;
					n.dat[psd_pkg::MODE_LSB +: psd_pkg::MODE_W] = q.mode;
				end
				psd_pkg::ADR_ASDC: begin
					n.dat[psd_pkg::ASDC_ASE] = q.asde;
					n.dat[psd_pkg::ASDC_EN] = q.asden;
					n.dat[psd_pkg::ASDC_OV] = q.ovr;
					n.dat[psd_pkg::ASDC_ARS] = q.arsen;
				end
				psd_pkg::ADR_ASDS: n.dat[N_SRC-1:0] = q.sel;
				psd_pkg::ADR_ASDL: n.dat[N_OUT-1:0] = q.lvl;
				psd_pkg::ADR_SYNC: begin
					n.dat[psd_pkg::SYNC_POF] = q.pofst;
					n.dat[N_MOD-1:0] = q.slv;
				end
				psd_pkg::ADR_PRD: n.dat[15:0] = q.prd_r;
				psd_pkg::ADR_PH: n.dat[15:0] = q.ph_r;
				psd_pkg::ADR_DC: n.dat[15:0] = q.dc_r;
				psd_pkg::ADR_FFA: n.dat[psd_pkg::FFA_W-1:0] = q.ffa;
				psd_pkg::ADR_STAT: begin
					n.dat[psd_pkg::STAT_HOLD] = (q.run == psd_pkg::RS_HOLD);
					n.dat[psd_pkg::STAT_WAVE] = q.wave;
					n.dat[psd_pkg::FFA_W-1:0] = q.acc;
				end
				default: n.dat = 32'h0000_0000;
			endcase
		end
		// Buffered copy at the period event
		if (q.en & q.ld & per_ev) begin
			n.prd_b = q.prd_r;
			n.ph_b = q.ph_r;
			n.dc_b = q.dc_r;
			n.ld = 1'b0;
		end
		if (acc_wr) begin
			case (wb_adr_i)
				psd_pkg::ADR_CTRL: begin
					n.en = wb_dat_i[psd_pkg::CTRL_EN];
					// Software set beats the hardware clear
					n.ld = wb_dat_i[psd_pkg::CTRL_LD] | n.ld;
					n.mode = wb_dat_i[psd_pkg::MODE_LSB +: psd_pkg::MODE_W];
				end
				psd_pkg::ADR_ASDC: begin
					n.asden = wb_dat_i[psd_pkg::ASDC_EN];
					n.ovr = wb_dat_i[psd_pkg::ASDC_OV];
					n.arsen = wb_dat_i[psd_pkg::ASDC_ARS];
					if (wb_dat_i[psd_pkg::ASDC_ASE]) begin
						n.asde = 1'b1;
					end else if (!hit) begin
						n.asde = 1'b0;
						n.by_src = 1'b0;
					end
				end
				psd_pkg::ADR_ASDS: n.sel = wb_dat_i[N_SRC-1:0];
				psd_pkg::ADR_ASDL: n.lvl = wb_dat_i[N_OUT-1:0];
				psd_pkg::ADR_SYNC: begin
					n.pofst = wb_dat_i[psd_pkg::SYNC_POF];
					n.slv = wb_dat_i[N_MOD-1:0];
				end
				psd_pkg::ADR_PRD: n.prd_r = wb_dat_i[15:0];
				psd_pkg::ADR_PH: n.ph_r = wb_dat_i[15:0];
				psd_pkg::ADR_DC: n.dc_r = wb_dat_i[15:0];
				psd_pkg::ADR_FFA: n.ffa = wb_dat_i[psd_pkg::FFA_W-1:0];
				default: n.irq = 1'b0;
			endcase
			// Idle module: writes land in the buffers too
			if (!q.en) begin
				n.prd_b = n.prd_r;
				n.ph_b = n.ph_r;
				n.dc_b = n.dc_r;
			end
		end
		// Auto restart only undoes a source-caused shutdown
		if (q.arsen & q.by_src & q.asde & ~hit) begin
			n.asde = 1'b0;
			n.by_src = 1'b0;
		end
		// Sources win over any clear in the same cycle
		if (hit) begin
			n.asde = 1'b1;
			n.by_src = 1'b1;
		end
		n.irq = n.asde & ~q.asde;
		// Resume only at a period event after the flag drops
		case (q.run)
			psd_pkg::RS_RUN: begin
				if (n.asde) begin
					n.run = psd_pkg::RS_HOLD;
				end
			end
			psd_pkg::RS_HOLD: begin
				if (!q.asde & !n.asde & per_ev) begin
					n.run = psd_pkg::RS_RUN;
				end
			end
			default: n.run = psd_pkg::RS_HOLD;
		endcase
		// Period counter
		if (!q.en) begin
			n.cnt = psd_pkg::ZERO16;
		end else if (per_ev) begin
			n.cnt = psd_pkg::ZERO16;
		end else begin
			n.cnt = q.cnt + 16'h0001;
		end
		// Fractional adjust, only in fixed duty modes
		if (per_ev) begin
			if (fixed) begin
				{n.ext, n.acc} = acc_sum;
			end else begin
				n.ext = 1'b0;
			end
		end
		// Waveform
		if (!q.en) begin
			n.wave = 1'b0;
		end else if (fixed) begin
			if (per_ev) begin
				n.wave = ~q.wave;
			end
		end else if (q.pofst ? per_ev : rise_ev) begin
			n.wave = 1'b1;
		end else if (q.cnt == q.dc_b) begin
			n.wave = 1'b0;
		end
		wave_v = '0;
		wave_v[0] = q.wave;
		wave_v[1] = (q.mode == psd_pkg::MODE_FIX_CMP) ? ~q.wave : 1'b0;
		n.pwm = ovr_on ? q.lvl : wave_v;
		// Sync out: one clock behind period, two behind rising
		n.rise_d = rise_ev;
		n.sync_o = q.pofst ? q.rise_d : per_ev;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q <= '0;
			q.prd_r <= psd_pkg::PRD_RST;
			q.prd_b <= psd_pkg::PRD_RST;
		end else begin
			q <= n;
		end
	end

	assign wb_dat_o  = q.dat;
	assign wb_ack_o  = q.ack;
	assign pwm_out   = q.pwm;
	assign sync_out  = q.sync_o;
	assign asd_event = q.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_rise_offset;
		rise_ev ##1 q.pofst;
	endsequence

	sequence s_quiet_flag;
		!q.asde ##1 !q.asde;
	endsequence

	chk_source_sets_flag: assert property (hit |=> q.asde)
		else $error("selected source did not set the shutdown flag");
	chk_flag_event_pulse: assert property ($rose(q.asde) |-> asd_event ##1 !asd_event)
		else $error("shutdown flag rise without a one-cycle event");
	chk_override_levels: assert property ((q.asde | q.ovr) |=> pwm_out == $past(q.lvl))
		else $error("pins not at override levels");
	chk_manual_flag_hold: assert property ((q.asde & !q.arsen & !wr_asdc) |=> q.asde)
		else $error("manual restart flag cleared without software");
	chk_override_no_event: assert property (s_quiet_flag |-> !asd_event)
		else $error("event pulse without shutdown flag rise");
	chk_period_sync_lag: assert property ((per_ev & !q.pofst) |=> sync_out)
		else $error("sync out missed one-clock period lag");
	chk_rise_sync_lag: assert property (s_rise_offset |=> sync_out)
		else $error("sync out missed two-clock rising lag");
	chk_load_transfer: assert property ((q.en & q.ld & per_ev & !wr_ctrl)
		|=> !q.ld && q.prd_b == $past(q.prd_r))
		else $error("load bit transfer failed");
	chk_adjust_mode_only: assert property ((per_ev & !fixed) |=> !q.ext)
		else $error("fractional stretch outside fixed duty mode");
	chk_fixed_toggle: assert property ((per_ev & fixed & q.en) |=> q.wave != $past(q.wave))
		else $error("fixed duty wave did not toggle");
endmodule

// ### dv/psd_far_model.sv
// Far side model: external shutdown sources and sibling master modules.
// Assumes the bench commands source levels and sync pulses through its tasks.
`timescale 1ns/100ps
module psd_far_model #(
	parameter int N_SRC = 4,
	parameter int N_MOD = 2
) (
	// Clock
	input  wire logic             clk,
	// Toward the block
	output logic      [N_SRC-1:0] src_lvl,
	output logic      [N_MOD-1:0] sync_pulse
);
	initial begin
		src_lvl    = '0;
		sync_pulse = '0;
	end
	// Level stays until told otherwise, never a pulse
	task automatic set_src(input logic [N_SRC-1:0] lvl);
		@(posedge clk);
		src_lvl <= lvl;
	endtask
	// One-cycle sync from the chosen master
	task automatic pulse(input logic [N_MOD-1:0] m);
		@(posedge clk);
		sync_pulse <= m;
		@(posedge clk);
		sync_pulse <= '0;
	endtask
endmodule

// ### dv/pwm_shutdown_sync_ffa_tb_top.sv
// Bench for the PWM shutdown, sync and fractional adjust block.
// Assumes psd_pkg and the far side model are compiled before it.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("mismatch at %0t got %h exp %h", $time, (g), (e)); end end
module pwm_shutdown_sync_ffa_tb_top;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we  = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [3:0]  sel_v = 4'hF;
	logic [31:0] dat = 32'h00000000;
	logic [31:0] dat_o;
	logic [31:0] rd;
	logic        ack;
	logic [3:0]  src;
	logic [1:0]  syn;
	logic [1:0]  pwm_out;
	logic        sync_out;
	logic        asd_event;
	logic        w2;
	logic        w3;
	int          fail_count = 0;
	int          tests_run  = 0;
	int          ev_cnt     = 0;
	int          e0, n1, n2, n3;

	always #25 clk = ~clk;
	always @(posedge clk) begin
		if (asd_event === 1'b1)
			ev_cnt <= ev_cnt + 1;
	end

	psd_core dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.asd_src_i(src), .sync_in(syn), .sync_out(sync_out), .pwm_out(pwm_out),
		.asd_event(asd_event));
	psd_far_model far (.clk(clk), .src_lvl(src), .sync_pulse(syn));

	task automatic give_verdict();
		if (fail_count == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// A used-up wait ends the run at once
	task automatic bound(input int i, input int lim);
		if (i >= lim) begin
			fail_count++;
			give_verdict();
		end
	endtask
	task automatic wbx(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		adr <= a;
		sel <= sel_v;
		dat <= d;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && i < 20);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		bound(i, 20);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wbx(1'b1, a, d);
	endtask
	task automatic rdr(input logic [7:0] a);
		wbx(1'b0, a, 32'h00000000);
	endtask
	// Cycles up to the next sync_out pulse, and the wave seen there
	task automatic gap(output int n, output logic w);
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (sync_out !== 1'b1 && n < 200);
		w = pwm_out[0];
		bound(n, 200);
	endtask
	task automatic wait_ev();
		n1 = 0;
		do begin
			@(posedge clk);
			n1++;
		end while (ev_cnt == e0 && n1 < 20);
		bound(n1, 20);
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rdr(psd_pkg::ADR_CTRL);
		`CHK(rd, 32'h00000000)
		rdr(8'h3C);
		`CHK(rd, 32'h00000000)
		wr(psd_pkg::ADR_PRD, 32'h00000009);
		wr(psd_pkg::ADR_FFA, 32'h00000008);
		// Byte lane 0 off: write is acked but must not land
		sel_v = 4'hE;
		wr(psd_pkg::ADR_FFA, 32'h00000005);
		sel_v = 4'hF;
		rdr(psd_pkg::ADR_FFA);
		`CHK(rd, 32'h00000008)
		wr(psd_pkg::ADR_ASDL, 32'h00000002);
		wr(psd_pkg::ADR_SYNC, 32'h00000001);
		wr(psd_pkg::ADR_CTRL, 32'h000000CA);
		far.pulse(2'b01);
		#1;
		`CHK(sync_out, 1'b1)
		rdr(psd_pkg::ADR_CTRL);
		`CHK(rd[6], 1'b0)
		wr(psd_pkg::ADR_SYNC, 32'h00000000);
		// Accumulator 8 of 16: one period in two is one clock longer
		gap(n1, w2);
		gap(n2, w2);
		gap(n3, w3);
		`CHK(n2 + n3, 21)
		`CHK(w3, ~w2)
		// Period sync leads the pin toggle by one clock
		@(posedge clk);
		#1;
		`CHK(pwm_out[0], ~w3)
		wr(psd_pkg::ADR_CTRL, 32'h00000080);
		gap(n1, w2);
		gap(n2, w2);
		gap(n3, w3);
		`CHK(n2 + n3, 20)
		wr(psd_pkg::ADR_CTRL, 32'h0000008B);
		gap(n1, w2);
		`CHK(pwm_out[1], ~pwm_out[0])
		e0 = ev_cnt;
		wr(psd_pkg::ADR_ASDC, 32'h000000C0);
		repeat (20) @(posedge clk);
		#1;
		`CHK(pwm_out, 2'b10)
		`CHK(ev_cnt, e0 + 1)
		wr(psd_pkg::ADR_ASDC, 32'h00000040);
		repeat (30) @(posedge clk);
		#1;
		`CHK(pwm_out[1], ~pwm_out[0])
		e0 = ev_cnt;
		wr(psd_pkg::ADR_ASDC, 32'h00000060);
		repeat (3) @(posedge clk);
		#1;
		`CHK(pwm_out, 2'b10)
		`CHK(ev_cnt, e0)
		wr(psd_pkg::ADR_ASDC, 32'h00000040);
		wr(psd_pkg::ADR_ASDS, 32'h00000001);
		far.set_src(4'h2);
		repeat (10) @(posedge clk);
		`CHK(ev_cnt, e0)
		far.set_src(4'h1);
		wait_ev();
		repeat (2) @(posedge clk);
		#1;
		`CHK(pwm_out, 2'b10)
		wr(psd_pkg::ADR_ASDC, 32'h00000040);
		rdr(psd_pkg::ADR_ASDC);
		`CHK(rd[7], 1'b1)
		far.set_src(4'h0);
		repeat (10) @(posedge clk);
		rdr(psd_pkg::ADR_ASDC);
		`CHK(rd[7], 1'b1)
		wr(psd_pkg::ADR_ASDC, 32'h00000040);
		rdr(psd_pkg::ADR_ASDC);
		`CHK(rd[7], 1'b0)
		wr(psd_pkg::ADR_ASDC, 32'h00000050);
		far.set_src(4'h1);
		repeat (10) @(posedge clk);
		rdr(psd_pkg::ADR_ASDC);
		`CHK(rd[7], 1'b1)
		far.set_src(4'h0);
		repeat (10) @(posedge clk);
		rdr(psd_pkg::ADR_ASDC);
		`CHK(rd[7], 1'b0)
		wr(psd_pkg::ADR_SYNC, 32'h00000080);
		gap(n1, w2);
		gap(n2, w2);
		gap(n3, w3);
		`CHK(n2 + n3, 21)
		// Rising sync trails the pin toggle, so no toggle follows it
		@(posedge clk);
		#1;
		`CHK(pwm_out[0], w3)
		give_verdict();
	end
endmodule
